// File: verilog/tsi_cfg.svh
// Purpose: constants for the teletype serial interface
// Assumes: 10 MHz mclk, AXI4-Lite register window of 32-bit words
// Notes: byte offsets, field positions, reset values and timing figures
`ifndef TSI_CFG_SVH
`define TSI_CFG_SVH

// register byte offsets
`define TSI_OFS_IOADDR 8'h00
`define TSI_OFS_MODECTL 8'h04
`define TSI_OFS_SKIP 8'h08
`define TSI_OFS_INPUT 8'h0c
`define TSI_OFS_OUTPUT 8'h10
`define TSI_OFS_MASK 8'h14
`define TSI_OFS_STATUS 8'h18

// address field of an i/o instruction
`define TSI_DEV_CODE 6'h04
`define TSI_DEV_LSB 0
`define TSI_DEV_MSB 5
`define TSI_MODE_BIT 6
`define TSI_FUNC_A_BIT 8

// status word fields
`define TSI_ST_READY 0
`define TSI_ST_BUSY 1
`define TSI_ST_SHIFT 2
`define TSI_ST_STOP 3
`define TSI_ST_OUTMODE 4
`define TSI_ST_LINE 5
`define TSI_ST_RXDATA 6

// stage patterns
`define TSI_STAGES_MARK 9'h1ff
`define TSI_STAGES_MODE 9'h001
`define TSI_STAGES_RST 9'h1ff

// bus answers
`define TSI_RESP_OKAY 2'h0
`define TSI_RESP_SLVERR 2'h2

// bit time of the current loop and the clock period
`define TSI_BIT_TIME_US 9091
`define TSI_CLK_PERIOD_NS 100
`define TSI_BIT_CYCLES ((`TSI_BIT_TIME_US * 1000) / `TSI_CLK_PERIOD_NS)

`endif

// File: verilog/tsi_pkg.sv
// Purpose: shared types of the teletype serial interface
// Assumes: nothing beyond the configuration header
// Notes: stage index 8 is the top stage, index 0 the final stage
package tsi_pkg;
	typedef logic [8:0] tsi_stages_t;
	typedef logic [9:0] tsi_code_t;
endpackage

// File: verilog/tsi_phase_clock.sv
// Purpose: two-phase bit clock, one shift slot per line bit period
// Assumes: run is the busy flip-flop, restarts are single-cycle pulses
// Notes: phase one leads phase two by one mclk inside each period
`timescale 1ns/1ns
`include "tsi_cfg.svh"
module tsi_phase_clock
	import tsi_pkg::*;
#(
	parameter int BIT_CYCLES = `TSI_BIT_CYCLES
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic run,
	input wire logic restartZero,
	input wire logic restartHalf,
	output logic phaseOne,
	output logic phaseTwo
);
	localparam int CW = $clog2(BIT_CYCLES);
	localparam logic [CW-1:0] LAST = CW'(BIT_CYCLES - 1);
	localparam logic [CW-1:0] HALF = CW'(BIT_CYCLES / 2);

	generate
		if (BIT_CYCLES < 4) begin : g_bad
			$error("tsi_phase_clock: BIT_CYCLES must be at least 4");
		end
	endgenerate

	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;

	// restart wins; a halted clock parks at zero
	assign cnt_d = restartHalf ? HALF :
		restartZero ? '0 :
		!run ? '0 :
		(cnt_q == LAST) ? '0 : cnt_q + CW'(1);

	// phases decode the count so both stop at once with busy
	assign phaseOne = run && (cnt_q == LAST - CW'(1));
	assign phaseTwo = run && (cnt_q == LAST);

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end
endmodule

// File: verilog/tsi_serial_if.sv
// Purpose: teletype serial interface with an AXI4-Lite register window
// Assumes: rxLine and txLine are current-loop levels, 1 = mark
// Notes: i/o instructions are issued as accesses to the window
`timescale 1ns/1ns
`include "tsi_cfg.svh"
// Notes on behaviour
// - receive: first shift enters a space marker
// - eight data bits enter top, stages shift down
// - marker at final stage clears shift enable
// - no shift, no sequence: phase two sets stop
// - ninth receive shift forces received data mark
// - stop drops busy, halts clock, sets ready
// - skip codes 0004/0204 answer with ready
// - ready and mask raise interrupt request
// - four input codes gate stages onto bus
// - read acknowledge with select clears ready
// - output instruction clears ready, makes load pulse
// - load: clear final, set busy, load, start
// - phase one sets shift enable; line sends space
// - transfer shows not ready and busy
// - transmit shifts down; line follows final stage
// - first transmit shift enters one, then zeros
// - end of character clears shift enable
// - stop plus sequence ends transmit, drops busy
// - output mode control: busy, final set, rest clear
// - no output by second phase one: busy drops
// - character: start space, eight data, two marks
// - selected on code xx04; bit six picks mode
// - input mode control sets stages to mark, clears flags
module tsi_serial_if
	import tsi_pkg::*;
#(
	parameter int BIT_CYCLES = `TSI_BIT_CYCLES
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic awvalid,
	output logic awready,
	input wire logic [7:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [7:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	input wire logic rxLine,
	output logic txLine,
	output logic interruptRequestLine
);
	// ---------------- bus slave ----------------
	logic awHeld_q, wHeld_q, awready_q, wready_q, bvalid_q;
	logic arready_q, rvalid_q;
	logic [7:0] wrAddr_q;
	logic [31:0] wrData_q;
	logic [3:0] wrStrb_q;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] rdata_q;
	logic awHeld_d, wHeld_d, bvalid_d, rvalid_d;
	logic awHandshake, wHandshake, arHandshake, doWrite;
	logic wrMapped, rdMapped;
	logic [31:0] rdWord;

	// address and data may arrive in either order; write once both held
	assign awHandshake = awvalid && awready_q;
	assign wHandshake = wvalid && wready_q;
	assign arHandshake = arvalid && arready_q;
	assign doWrite = awHeld_q && wHeld_q;
	assign awHeld_d = (awHeld_q || awHandshake) && !doWrite;
	assign wHeld_d = (wHeld_q || wHandshake) && !doWrite;
	assign bvalid_d = (bvalid_q && !bready) || doWrite;
	assign rvalid_d = (rvalid_q && !rready) || arHandshake;
	assign wrMapped = (wrAddr_q == `TSI_OFS_IOADDR) ||
		(wrAddr_q == `TSI_OFS_MODECTL) ||
		(wrAddr_q == `TSI_OFS_OUTPUT) ||
		(wrAddr_q == `TSI_OFS_MASK);
	assign rdMapped = (araddr == `TSI_OFS_IOADDR) ||
		(araddr == `TSI_OFS_SKIP) || (araddr == `TSI_OFS_INPUT) ||
		(araddr == `TSI_OFS_MASK) || (araddr == `TSI_OFS_STATUS);

	// ready falls while a request is held, so one write at a time
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			awHeld_q <= 1'b0;
			wHeld_q <= 1'b0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= `TSI_RESP_OKAY;
			wrAddr_q <= 8'h00;
			wrData_q <= 32'h0000_0000;
			wrStrb_q <= 4'h0;
		end else begin
			awHeld_q <= awHeld_d;
			wHeld_q <= wHeld_d;
			awready_q <= !awHeld_d && !bvalid_d;
			wready_q <= !wHeld_d && !bvalid_d;
			bvalid_q <= bvalid_d;
			if (doWrite) begin
				bresp_q <= wrMapped ? `TSI_RESP_OKAY : `TSI_RESP_SLVERR;
			end
			if (awHandshake) begin
				wrAddr_q <= awaddr;
			end
			if (wHandshake) begin
				wrData_q <= wdata;
				wrStrb_q <= wstrb;
			end
		end
	end

	// reads answer one edge after the address is taken
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= `TSI_RESP_OKAY;
		end else begin
			arready_q <= !rvalid_d;
			rvalid_q <= rvalid_d;
			if (arHandshake) begin
				rdata_q <= rdMapped ? rdWord : 32'h0000_0000;
				rresp_q <= rdMapped ? `TSI_RESP_OKAY : `TSI_RESP_SLVERR;
			end
		end
	end

	assign awready = awready_q;
	assign wready = wready_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign arready = arready_q;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;

	// ---------------- instruction decode ----------------
	tsi_code_t ioAddr_q;
	logic interruptMaskFf_q;
	logic deviceSelected, modeControlInstr, outputFromAccInstr;
	logic inputToAccInstr, inputCodeOk, readAckStrobe;
	logic outEnable, inEnable, readyClearStrobe, outputLoadPulse;
	logic busyTest, skipAnswer;
	logic strb0;

	// address field latched by software, used by every instruction
	assign strb0 = wrStrb_q[0];
	assign deviceSelected =
		(ioAddr_q[`TSI_DEV_MSB:`TSI_DEV_LSB] == `TSI_DEV_CODE);
	assign modeControlInstr = doWrite && strb0 &&
		(wrAddr_q == `TSI_OFS_MODECTL) && deviceSelected;
	assign outEnable = modeControlInstr && ioAddr_q[`TSI_MODE_BIT];
	assign inEnable = modeControlInstr && !ioAddr_q[`TSI_MODE_BIT];
	assign outputFromAccInstr = doWrite && strb0 &&
		(wrAddr_q == `TSI_OFS_OUTPUT) && deviceSelected;
	assign inputToAccInstr = arHandshake && (araddr == `TSI_OFS_INPUT);
	// codes 0004, 1004, 0204, 1204 leave bits six and eight clear
	assign inputCodeOk = deviceSelected && !ioAddr_q[`TSI_MODE_BIT] &&
		!ioAddr_q[`TSI_FUNC_A_BIT];
	assign readAckStrobe = inputToAccInstr && inputCodeOk;
	assign readyClearStrobe = readAckStrobe || outputFromAccInstr;

	// ---------------- sequence flip-flops ----------------
	tsi_stages_t stages_q, stages_d;
	logic shiftEnableFf_q, secondSequenceFf_q, stopFf_q, busyFf_q;
	logic readyFf_q, outputStartFf_q, outputModeFf_q;
	logic dummyArm_q, dummyCount_q;
	logic rxSync1_q, rxSync2_q, rxPrev_q;
	logic lineDriver_q, irq_q;
	logic phaseOneClock, phaseTwoClock, shiftPulse;
	logic finalBufferStage, topBufferStage, receivedDataSignal;
	logic endOfCharacter, rxStart, fillBit, firstRxShift;
	logic shiftEnable_d, secondSequence_d, stop_d, busy_d, ready_d;
	logic outputStart_d, outputMode_d, dummyArm_d, dummyCount_d;
	logic rxDone, txDone, dummyExpire;

	// fixed stage patterns, kept as vectors so each stage picks its bit
	localparam tsi_stages_t STAGES_MARK = `TSI_STAGES_MARK;
	localparam tsi_stages_t STAGES_MODE = `TSI_STAGES_MODE;
	tsi_stages_t loadWord;

	assign finalBufferStage = stages_q[0];
	assign topBufferStage = stages_q[8];

	// a load while a character is going out is refused
	assign outputLoadPulse = outputFromAccInstr && outputModeFf_q &&
		(!busyFf_q || dummyArm_q);

	// receive starts on the start-bit edge, only with no character held
	assign rxStart = !outputModeFf_q && !busyFf_q && !readyFf_q &&
		rxPrev_q && !rxSync2_q;

	tsi_phase_clock #(
		.BIT_CYCLES(BIT_CYCLES)
	) u_phase (
		.mclk(mclk),
		.reset(reset),
		.run(busyFf_q),
		.restartZero(outputLoadPulse || outEnable),
		.restartHalf(rxStart),
		.phaseOne(phaseOneClock),
		.phaseTwo(phaseTwoClock)
	);

	// one shift per period, at mid-bit when receiving
	assign shiftPulse = phaseTwoClock && shiftEnableFf_q;

	// received data is held mark once the marker has arrived
	assign receivedDataSignal = !finalBufferStage ? 1'b1 : rxSync2_q;
	assign firstRxShift = (stages_q == `TSI_STAGES_MARK);
	assign endOfCharacter = outputModeFf_q &&
		(stages_q == `TSI_STAGES_MODE);
	assign fillBit = outputModeFf_q ? outputStartFf_q :
		firstRxShift ? 1'b0 : receivedDataSignal;

	// per-stage next value: stages below the top copy the one above on a shift, the top takes the fill bit
	assign loadWord = {wrData_q[7:0], 1'b0};
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_stage
			assign stages_d[gi] = inEnable ? STAGES_MARK[gi] :
				outEnable ? STAGES_MODE[gi] :
				outputLoadPulse ? loadWord[gi] :
				rxStart ? 1'b1 :
				shiftPulse ? stages_q[gi+1] : stages_q[gi];
		end
	endgenerate
	assign stages_d[8] = inEnable ? STAGES_MARK[8] :
		outEnable ? STAGES_MODE[8] :
		outputLoadPulse ? loadWord[8] :
		rxStart ? 1'b1 :
		shiftPulse ? fillBit : topBufferStage;

	// completions of the three kinds of cycle
	assign rxDone = !outputModeFf_q && stopFf_q;
	assign txDone = outputModeFf_q && secondSequenceFf_q &&
		finalBufferStage;
	assign dummyExpire = dummyArm_q && phaseOneClock && dummyCount_q;

	// shift enable: set on phase one, cleared by marker or end code
	assign shiftEnable_d =
		(inEnable || outEnable || rxStart) ? 1'b0 :
		!phaseOneClock ? shiftEnableFf_q :
		outputModeFf_q ?
			(endOfCharacter ? 1'b0 :
			(!finalBufferStage && !secondSequenceFf_q) ? 1'b1 :
			shiftEnableFf_q) :
		(!finalBufferStage ? 1'b0 :
		!stopFf_q ? 1'b1 : shiftEnableFf_q);

	// stop is set by phase two once shifting and sequence are idle
	assign stop_d = (inEnable || outEnable || rxDone || txDone) ? 1'b0 :
		(phaseTwoClock && !shiftEnableFf_q && !secondSequenceFf_q &&
		!dummyArm_q) ? 1'b1 : stopFf_q;

	// second stop bit: one more period of mark before the end
	assign secondSequence_d = (inEnable || outEnable || txDone) ? 1'b0 :
		(phaseTwoClock && stopFf_q && outputModeFf_q) ? 1'b1 :
		secondSequenceFf_q;

	// busy gates the phase clock
	assign busy_d = (outEnable || outputLoadPulse || rxStart) ? 1'b1 :
		(inEnable || rxDone || txDone || dummyExpire) ? 1'b0 :
		busyFf_q;

	// set wins over the clear strobe arriving in the same cycle
	assign ready_d = (rxDone || txDone || dummyExpire) ? 1'b1 :
		(readyClearStrobe || inEnable) ? 1'b0 : readyFf_q;

	assign outputStart_d = outputLoadPulse ? 1'b1 :
		(shiftPulse && outputModeFf_q) ? 1'b0 : outputStartFf_q;
	assign outputMode_d = outEnable ? 1'b1 :
		inEnable ? 1'b0 : outputModeFf_q;

	// dummy cycle counts phase-one pulses after output mode control
	assign dummyArm_d = outEnable ? 1'b1 :
		(outputLoadPulse || inEnable || dummyExpire) ? 1'b0 : dummyArm_q;
	assign dummyCount_d = (outEnable || outputLoadPulse || inEnable) ?
		1'b0 : (dummyArm_q && phaseOneClock) ? 1'b1 : dummyCount_q;

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			stages_q <= `TSI_STAGES_RST;
			shiftEnableFf_q <= 1'b0;
			secondSequenceFf_q <= 1'b0;
			stopFf_q <= 1'b0;
			busyFf_q <= 1'b0;
			readyFf_q <= 1'b0;
			outputStartFf_q <= 1'b0;
			outputModeFf_q <= 1'b0;
			dummyArm_q <= 1'b0;
			dummyCount_q <= 1'b0;
		end else begin
			stages_q <= stages_d;
			shiftEnableFf_q <= shiftEnable_d;
			secondSequenceFf_q <= secondSequence_d;
			stopFf_q <= stop_d;
			busyFf_q <= busy_d;
			readyFf_q <= ready_d;
			outputStartFf_q <= outputStart_d;
			outputModeFf_q <= outputMode_d;
			dummyArm_q <= dummyArm_d;
			dummyCount_q <= dummyCount_d;
		end
	end

	// software registers: address field and interrupt mask
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			ioAddr_q <= '0;
			interruptMaskFf_q <= 1'b0;
		end else if (doWrite && wrAddr_q == `TSI_OFS_IOADDR) begin
			if (wrStrb_q[0]) ioAddr_q[7:0] <= wrData_q[7:0];
			if (wrStrb_q[1]) ioAddr_q[9:8] <= wrData_q[9:8];
		end else if (doWrite && strb0 && wrAddr_q == `TSI_OFS_MASK) begin
			interruptMaskFf_q <= wrData_q[0];
		end
	end

	// line input passes two flops; the edge detector reads the second
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			rxSync1_q <= 1'b1;
			rxSync2_q <= 1'b1;
			rxPrev_q <= 1'b1;
			lineDriver_q <= 1'b1;
			irq_q <= 1'b0;
		end else begin
			rxSync1_q <= rxLine;
			rxSync2_q <= rxSync1_q;
			rxPrev_q <= rxSync2_q;
			lineDriver_q <= !outputModeFf_q || finalBufferStage;
			irq_q <= readyFf_q && interruptMaskFf_q;
		end
	end

	assign txLine = lineDriver_q;
	assign interruptRequestLine = irq_q;

	// ---------------- read data ----------------
	// skip codes: bit six set tests not busy, else tests ready
	assign busyTest = ioAddr_q[`TSI_MODE_BIT];
	assign skipAnswer = deviceSelected && !ioAddr_q[`TSI_FUNC_A_BIT] &&
		(busyTest ? !busyFf_q : readyFf_q);
	assign rdWord =
		(araddr == `TSI_OFS_IOADDR) ? {22'h0, ioAddr_q} :
		(araddr == `TSI_OFS_SKIP) ? {31'h0, skipAnswer} :
		(araddr == `TSI_OFS_INPUT) ?
			(inputCodeOk ? {24'h0, stages_q[8:1]} : 32'h0) :
		(araddr == `TSI_OFS_MASK) ? {31'h0, interruptMaskFf_q} :
		(araddr == `TSI_OFS_STATUS) ? {25'h0,
			receivedDataSignal, lineDriver_q, outputModeFf_q,
			stopFf_q, shiftEnableFf_q, busyFf_q, readyFf_q} :
		32'h0;
endmodule

// File: tb/tsi_serial_if_properties.sv
// Purpose: port-level checks of the teletype serial interface
// Assumes: one mclk domain, asynchronous active-high reset
// Notes: line bit lengths are judged through a run-length counter
`timescale 1ns/1ns
`include "tsi_cfg.svh"
module tsi_props #(
	parameter int BIT_CYCLES = 8
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [7:0] araddr,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic txLine
);
	logic lineQ;
	int runCnt;
	logic badRd;
	// unmapped or write-only offsets must answer with an error
	assign badRd = araddr > `TSI_OFS_STATUS ||
		araddr == `TSI_OFS_MODECTL || araddr == `TSI_OFS_OUTPUT;
	// run length of the present line level; idle mark after reset
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			lineQ <= 1'b1;
			runCnt <= 0;
		end else begin
			lineQ <= txLine;
			runCnt <= (txLine != lineQ) ? 1 : runCnt + 1;
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	property p_bHold;
		bvalid && !bready |=> bvalid;
	endproperty
	a_bHold: assert property (p_bHold) else $error("bvalid dropped");
	property p_rHold;
		rvalid && !rready |=> rvalid && $stable(rdata);
	endproperty
	a_rHold: assert property (p_rHold) else $error("read data moved");
	property p_wRefuse;
		bvalid |-> !awready && !wready;
	endproperty
	a_wRefuse: assert property (p_wRefuse) else $error("write open");
	property p_rRefuse;
		rvalid |-> !arready;
	endproperty
	a_rRefuse: assert property (p_rRefuse) else $error("read open");
	property p_wLat;
		awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid;
	endproperty
	a_wLat: assert property (p_wLat) else $error("write answer late");
	property p_rResp;
		arvalid && arready && araddr[1:0] == 2'h0 |=> rvalid
			&& rresp == ($past(badRd) ? `TSI_RESP_SLVERR : `TSI_RESP_OKAY);
	endproperty
	a_rResp: assert property (p_rResp) else $error("read answer wrong");
	property p_lowRun;
		$rose(txLine) |-> runCnt != 0 && runCnt % BIT_CYCLES == 0
			&& runCnt <= 9 * BIT_CYCLES;
	endproperty
	a_lowRun: assert property (p_lowRun) else $error("space run");
	property p_highRun;
		$fell(txLine) |-> runCnt >= BIT_CYCLES;
	endproperty
	a_highRun: assert property (p_highRun) else $error("mark run");
endmodule

bind tsi_serial_if tsi_props #(.BIT_CYCLES(BIT_CYCLES)) i_props (
	.mclk(mclk), .reset(reset), .awvalid(awvalid), .awready(awready),
	.wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
	.arvalid(arvalid), .arready(arready), .araddr(araddr),
	.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
	.txLine(txLine)
);

// File: tb/tsi_tty_model.sv
// Purpose: behavioural current-loop terminal on the serial pins
// Assumes: 1 = mark, idle line marking
// Notes: printer samples mid-bit, so a bit shorter than half fails
`timescale 1ns/1ns
module tsi_tty_model #(
	parameter int BIT_CYCLES = 8
) (
	input wire logic mclk,
	input wire logic txLine,
	output logic rxLine,
	output logic [7:0] gotChar,
	output logic gotStop,
	output int gotCount
);
	logic [10:0] frame;
	initial begin
		rxLine = 1'b1;
		gotChar = 8'h00;
		gotStop = 1'b0;
		gotCount = 0;
	end
	// keyboard: start space, eight bits lsb first, two mark stops
	task automatic sendChar(input logic [7:0] c);
		logic [10:0] f;
		f = {2'b11, c, 1'b0};
		for (int i = 0; i < 11; i++) begin
			rxLine <= f[i];
			repeat (BIT_CYCLES) @(posedge mclk);
		end
	endtask
	// printer: start edge, then one sample in the middle of each bit
	always begin
		@(negedge txLine);
		repeat (BIT_CYCLES / 2) @(posedge mclk);
		for (int i = 0; i < 11; i++) begin
			frame[i] = txLine;
			repeat (BIT_CYCLES) @(posedge mclk);
		end
		gotChar = frame[8:1];
		gotStop = frame[10:9] == 2'b11 && !frame[0];
		gotCount++;
	end
endmodule

// File: tb/tsi_tb_top.sv
// Purpose: self-checking bench of the teletype serial interface
// Assumes: short bit period, AXI4-Lite master tasks
// Notes: each scenario task drives and judges on its own
`timescale 1ns/1ns
`include "tsi_cfg.svh"
`define CHK(nm, ex, gt) begin \
	compares++; \
	if ((gt) !== (ex)) begin \
		fails++; \
		$display("mismatch %s exp %h got %h", nm, ex, gt); \
	end \
end
module tb_top;
	localparam int BC = 8;
	logic mclk, reset, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, rxLine, txLine, irq;
	logic [7:0] awaddr, araddr, gotChar;
	logic [31:0] wdata, rdata, rdv;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rsp;
	logic gotStop;
	int gotCount, fails, compares;
	tsi_serial_if #(.BIT_CYCLES(BC)) i_dut (
		.mclk(mclk), .reset(reset), .awvalid(awvalid), .awready(awready),
		.awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
		.wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.rxLine(rxLine), .txLine(txLine), .interruptRequestLine(irq)
	);
	tsi_tty_model #(.BIT_CYCLES(BC)) i_tty (
		.mclk(mclk), .txLine(txLine), .rxLine(rxLine), .gotChar(gotChar),
		.gotStop(gotStop), .gotCount(gotCount)
	);
	always #50 mclk = ~mclk;
	// address and data go out together, bready held until the answer
	task automatic axWrite(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge mclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		rsp = bresp;
		bready <= 1'b0;
	endtask
	task automatic axRead(input logic [7:0] a);
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge mclk);
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rdv = rdata;
		rsp = rresp;
		rready <= 1'b0;
	endtask
	task automatic setAddr(input logic [9:0] code);
		axWrite(`TSI_OFS_IOADDR, {22'h0, code});
	endtask
	task automatic t_idle;
		axRead(`TSI_OFS_STATUS);
		`CHK("idle line", rdv[`TSI_ST_LINE], 1'b1)
		`CHK("idle busy", rdv[`TSI_ST_BUSY], 1'b0)
		axRead(8'h1c);
		`CHK("bad read", {rsp, rdv}, {`TSI_RESP_SLVERR, 32'h0})
		axWrite(8'h1c, 32'h0);
		`CHK("bad write", rsp, `TSI_RESP_SLVERR)
	endtask
	// first character right after mode control, second after the dummy
	task automatic t_transmit;
		logic [7:0] c;
		int n0;
		for (int k = 0; k < 2; k++) begin
			c = k ? 8'h3c : 8'ha5;
			setAddr(10'h044);
			axWrite(`TSI_OFS_MODECTL, 32'h44);
			if (k == 1) begin
				repeat (3 * BC) @(posedge mclk);
				axRead(`TSI_OFS_STATUS);
				`CHK("dummy busy", rdv[`TSI_ST_BUSY], 1'b0)
			end
			n0 = gotCount;
			axWrite(`TSI_OFS_OUTPUT, {24'h0, c});
			axRead(`TSI_OFS_SKIP);
			`CHK("skip not busy", rdv[0], 1'b0)
			axRead(`TSI_OFS_STATUS);
			`CHK("tx ready", rdv[`TSI_ST_READY], 1'b0)
			for (int i = 0; i < 20 * BC && gotCount == n0; i++)
				@(posedge mclk);
			`CHK("tx char", gotChar, c)
			`CHK("tx frame", gotStop, 1'b1)
			for (int i = 0; i < 20; i++) begin
				axRead(`TSI_OFS_STATUS);
				if (rdv[`TSI_ST_BUSY] === 1'b0) break;
			end
			`CHK("tx end", rdv[1:0], 2'b01)
		end
	endtask
	// two characters, interrupt mask off then on
	task automatic t_receive;
		logic [7:0] c;
		logic [9:0] codes [4];
		codes = '{10'h004, 10'h204, 10'h084, 10'h284};
		setAddr(10'h004);
		axWrite(`TSI_OFS_MODECTL, 32'h4);
		axRead(`TSI_OFS_STATUS);
		`CHK("in mode", {rdv[4], rdv[0]}, 2'b00)
		for (int m = 0; m < 2; m++) begin
			c = m ? 8'hc3 : 8'h5a;
			axWrite(`TSI_OFS_MASK, 32'(m));
			i_tty.sendChar(c);
			repeat (4) @(posedge mclk);
			`CHK("irq", irq, m[0])
			for (int i = 0; i < 3; i++) begin
				setAddr(i == 2 ? 10'h005 : (i ? 10'h084 : 10'h004));
				axRead(`TSI_OFS_SKIP);
				`CHK("skip ready", rdv[0], i != 2)
			end
			for (int i = 0; i < 4; i++) begin
				setAddr(codes[i]);
				axRead(`TSI_OFS_INPUT);
				`CHK("char in", rdv[7:0], c)
			end
			setAddr(10'h104);
			axRead(`TSI_OFS_INPUT);
			`CHK("bad code", rdv, 32'h0)
			setAddr(10'h004);
			axRead(`TSI_OFS_SKIP);
			`CHK("ready cleared", rdv[0], 1'b0)
			`CHK("irq cleared", irq, 1'b0)
		end
	endtask
	task automatic finish_test;
		if (fails == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// hang guard, well beyond the several hundred cycles of the run
	initial begin
		repeat (20000) @(posedge mclk);
		fails++;
		finish_test();
	end
	initial begin
		mclk = 1'b0;
		reset = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		wstrb = 4'hf;
		fails = 0;
		compares = 0;
		repeat (5) @(posedge mclk);
		reset <= 1'b0;
		t_idle();
		t_transmit();
		t_receive();
		finish_test();
	end
endmodule
